// File: shared/srg_pkg.sv
package srg_pkg;
   // clock rate
   localparam int unsigned CLK_KHZ = 200000;
   localparam int unsigned CLK_PERIOD_PS = 5000;
   // reset timeout, nominal with its window
   localparam int unsigned RESET_TIMEOUT_MS = 200;
   localparam int unsigned RESET_TIMEOUT_MIN_MS = 130;
   localparam int unsigned RESET_TIMEOUT_MAX_MS = 270;
   localparam int unsigned RESET_TIMEOUT_CYC = RESET_TIMEOUT_MS * CLK_KHZ;
   // longest allowed delay from trip to reset assertion
   localparam int unsigned TRIP_TO_ASSERT_US = 5;
   localparam int unsigned TRIP_TO_ASSERT_CYC = (TRIP_TO_ASSERT_US * 1000000) / CLK_PERIOD_PS;
   // supply dips up to this width are ignored (longest, rounded down)
   localparam int unsigned SUPPLY_DIP_REJECT_NS = 30;
   localparam int unsigned SUPPLY_DIP_REJECT_CYC = (SUPPLY_DIP_REJECT_NS * 1000) / CLK_PERIOD_PS;
   localparam int unsigned SUPPLY_HOLD_CYC = SUPPLY_DIP_REJECT_CYC + 1;
   // manual pulses shorter than this are ignored (least, rounded up)
   localparam int unsigned MANUAL_GLITCH_NS = 100;
   localparam int unsigned MANUAL_HOLD_CYC = (MANUAL_GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // sync depth plus filter plus margin before the released pin is trusted
   localparam int unsigned SYNC_DEPTH = 3;
   localparam int unsigned PIN_SETTLE_CYC = SYNC_DEPTH + MANUAL_HOLD_CYC + 2;
   // internal program cycle, longest
   localparam int unsigned PROGRAM_CYCLE_MS = 5;
   localparam int unsigned PROGRAM_CYCLE_CYC = PROGRAM_CYCLE_MS * CLK_KHZ;
   // wait the controller keeps before its first memory access
   localparam int unsigned POWERUP_TO_READ_WAIT_MS = 270;
   localparam int unsigned POWERUP_TO_WRITE_WAIT_MS = 270;
   // counter width
   localparam int unsigned CNT_W = 32;

   typedef enum logic [2:0] {
      SRG_SUPPLY_LOW,
      SRG_TIMEOUT,
      SRG_SETTLE,
      SRG_EXT_HOLD,
      SRG_RUN
   } srg_state_e;
endpackage

// File: design/srg_filt.sv
`timescale 1ns/1ps
module srg_filt #(
   parameter int unsigned HOLD = 1,
   parameter bit INIT = 1'b0
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // asynchronous level in, filtered level out
   input wire logic raw,
   output logic clean
);
   logic sync1;
   logic sync2;
   logic sync3;
   logic [srg_pkg::CNT_W-1:0] run_cnt;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sync1 <= INIT;
         sync2 <= INIT;
         sync3 <= INIT;
      end else begin
         sync1 <= raw;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // a new level must stay put for HOLD agreed samples before it counts
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         run_cnt <= '0;
         clean <= INIT;
      end else if (sync2 != sync3 || sync3 == clean) begin
         run_cnt <= '0;
      end else if (run_cnt >= srg_pkg::CNT_W'(HOLD - 1)) begin
         run_cnt <= '0;
         clean <= sync3;
      end else begin
         run_cnt <= run_cnt + 1'b1;
      end
   end
endmodule

// File: design/srg_supervisor.sv
`timescale 1ns/1ps
// Function
// - hold reset while supply is low and for the timeout after recovery
// - after the timeout stop driving the open-drain reset pin
// - assert reset within 5 us of the supply falling below trip level
// - supply dips of 30 ns or less never assert reset
// - a high-to-low manual edge on the reset pin in RUN starts a fresh timeout
// - a short external reset in RUN still yields the full 200 ms reset
// - manual pulses under 100 ns start no reset interval
// - while in reset the memory is disabled for reads and writes
// - entering reset aborts a bus transaction and refuses new ones
// - no program cycle starts in reset; a running one completes
// - each program cycle ends within 5 ms of its closing stop
// - while programming the bus is off, data released, address not acknowledged
// - only the active-low variant takes the pin as a manual input
module srg_supervisor #(
   parameter bit ACTIVE_LOW = 1'b1,
   parameter int unsigned RESET_TIMEOUT_CYC = srg_pkg::RESET_TIMEOUT_CYC,
   parameter int unsigned PROGRAM_CYCLE_CYC = srg_pkg::PROGRAM_CYCLE_CYC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // analog comparator, high while supply is below trip level
   input wire logic supply_below,
   // reset pin: level seen, value driven, drive enable
   input wire logic rst_pin_in,
   output logic rst_pin_out,
   output logic rst_pin_oe,
   // serial front end, same clock
   input wire logic bus_busy,
   input wire logic write_stop,
   // memory guard
   output logic mem_enable,
   output logic bus_enable,
   output logic bus_abort,
   output logic prog_start,
   output logic prog_busy
);
   srg_pkg::srg_state_e state;
   logic [srg_pkg::CNT_W-1:0] tmo_cnt;
   logic [srg_pkg::CNT_W-1:0] settle_cnt;
   logic [srg_pkg::CNT_W-1:0] prog_cnt;
   logic supply_low;
   logic pin_active;
   logic manual_seen;
   logic reset_cond;
   logic reset_cond_q;
   logic pin_raw;

   function automatic logic cnt_done(input logic [srg_pkg::CNT_W-1:0] cnt, input int unsigned lim);
      cnt_done = (cnt >= srg_pkg::CNT_W'(lim - 1));
   endfunction

   srg_filt #(
      .HOLD(srg_pkg::SUPPLY_HOLD_CYC),
      .INIT(1'b1)
   ) u_supply_filt (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .raw(supply_below),
      .clean(supply_low)
   );

   // pin normalised so that 1 means the reset level
   assign pin_raw = ACTIVE_LOW ? ~rst_pin_in : rst_pin_in;

   srg_filt #(
      .HOLD(srg_pkg::MANUAL_HOLD_CYC),
      .INIT(1'b0)
   ) u_pin_filt (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .raw(pin_raw),
      .clean(pin_active)
   );

   // only active-low parts listen to the pin
   assign manual_seen = ACTIVE_LOW && pin_active;

   // the pin reads back our own drive, so it is only trusted at the end of the settle window, in SRG_EXT_HOLD and in RUN,
   // all after a settle window once the drive was released
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state <= srg_pkg::SRG_SUPPLY_LOW;
      end else if (supply_low) begin
         state <= srg_pkg::SRG_SUPPLY_LOW;
      end else begin
         case (state)
            srg_pkg::SRG_SUPPLY_LOW: begin
               state <= srg_pkg::SRG_TIMEOUT;
            end
            srg_pkg::SRG_TIMEOUT: begin
               if (cnt_done(tmo_cnt, RESET_TIMEOUT_CYC)) begin
                  state <= srg_pkg::SRG_SETTLE;
               end
            end
            srg_pkg::SRG_SETTLE: begin
               if (cnt_done(settle_cnt, srg_pkg::PIN_SETTLE_CYC)) begin
                  state <= manual_seen ? srg_pkg::SRG_EXT_HOLD : srg_pkg::SRG_RUN;
               end
            end
            srg_pkg::SRG_EXT_HOLD: begin
               // forced pin keeps the reset condition until it lets go
               if (!manual_seen) begin
                  state <= srg_pkg::SRG_RUN;
               end
            end
            srg_pkg::SRG_RUN: begin
               if (manual_seen) begin
                  state <= srg_pkg::SRG_TIMEOUT;
               end
            end
            default: begin
               state <= srg_pkg::SRG_SUPPLY_LOW;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tmo_cnt <= '0;
      end else if (state != srg_pkg::SRG_TIMEOUT) begin
         tmo_cnt <= '0;
      end else begin
         // full interval whatever the pin does
         tmo_cnt <= tmo_cnt + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         settle_cnt <= '0;
      end else if (state != srg_pkg::SRG_SETTLE) begin
         settle_cnt <= '0;
      end else begin
         settle_cnt <= settle_cnt + 1'b1;
      end
   end

   // the filtered trip counts at once, so memory, bus and abort move on the same edge as the pin drive
   assign reset_cond = (state != srg_pkg::SRG_RUN) || supply_low;

   // drive while low or timing out
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_pin_oe <= 1'b1;
         rst_pin_out <= ~ACTIVE_LOW;
      end else begin
         rst_pin_oe <= (state == srg_pkg::SRG_SUPPLY_LOW) || (state == srg_pkg::SRG_TIMEOUT) || supply_low;
         rst_pin_out <= ~ACTIVE_LOW;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         mem_enable <= 1'b0;
         reset_cond_q <= 1'b1;
      end else begin
         mem_enable <= ~reset_cond;
         reset_cond_q <= reset_cond;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         bus_abort <= 1'b0;
      end else begin
         bus_abort <= reset_cond && !reset_cond_q && bus_busy;
      end
   end

   // bus off while programming or in reset
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         bus_enable <= 1'b0;
      end else begin
         bus_enable <= !reset_cond && !prog_busy && !(write_stop && !prog_busy);
      end
   end

   // start refused in reset, running cycle never cut
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         prog_busy <= 1'b0;
         prog_start <= 1'b0;
         prog_cnt <= '0;
      end else if (prog_busy) begin
         prog_start <= 1'b0;
         if (cnt_done(prog_cnt, PROGRAM_CYCLE_CYC)) begin
            prog_busy <= 1'b0;
            prog_cnt <= '0;
         end else begin
            prog_cnt <= prog_cnt + 1'b1;
         end
      end else if (write_stop && mem_enable && !reset_cond) begin
         prog_busy <= 1'b1;
         prog_start <= 1'b1;
         prog_cnt <= '0;
      end else begin
         prog_start <= 1'b0;
      end
   end
endmodule

// File: tb/srg_properties.sv
`timescale 1ns/1ps
module srg_properties #(
   parameter int unsigned RESET_TIMEOUT_CYC = 200,
   parameter int unsigned PROGRAM_CYCLE_CYC = 50
) (
   // watched ports
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic supply_below,
   input wire logic bus_busy,
   input wire logic write_stop,
   input wire logic rst_pin_oe,
   input wire logic mem_enable,
   input wire logic bus_enable,
   input wire logic bus_abort,
   input wire logic prog_start,
   input wire logic prog_busy
);
   int unsigned oe_cnt;
   int unsigned pb_cnt;
   // run lengths of the high level of both signals, so hold times need no long repetition
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         oe_cnt <= 0;
         pb_cnt <= 0;
      end else begin
         oe_cnt <= rst_pin_oe ? oe_cnt + 1 : 0;
         pb_cnt <= prog_busy ? pb_cnt + 1 : 0;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   sequence s_trip;
      supply_below [*8];
   endsequence
   sequence s_prog_end;
      $fell(prog_busy);
   endsequence
   a_trip_asserts: assert property (s_trip |-> ##[0:1000] rst_pin_oe)
      else $error("reset late after trip");
   a_timeout_hold: assert property ($fell(rst_pin_oe) |-> oe_cnt >= RESET_TIMEOUT_CYC - 1)
      else $error("reset released early");
   a_mem_gated: assert property (rst_pin_oe |-> !mem_enable)
      else $error("memory on in reset");
   a_bus_refused: assert property ((!mem_enable || rst_pin_oe) |-> !bus_enable)
      else $error("bus on in reset");
   a_abort_pulse: assert property (bus_abort |-> $rose(rst_pin_oe) && $past(bus_busy) ##1 !bus_abort)
      else $error("stray abort");
   a_start_gate: assert property (prog_start |->
      $past(write_stop) && $past(mem_enable) && !$past(prog_busy)) else $error("bad program start");
   a_prog_length: assert property (s_prog_end |-> pb_cnt == PROGRAM_CYCLE_CYC)
      else $error("program length wrong");
   a_prog_bus_off: assert property (prog_busy |-> !bus_enable)
      else $error("bus on while programming");
endmodule
bind srg_supervisor srg_properties #(.RESET_TIMEOUT_CYC(RESET_TIMEOUT_CYC), .PROGRAM_CYCLE_CYC(PROGRAM_CYCLE_CYC))
   srg_properties_inst (.ref_clk(ref_clk), .nrst(nrst), .supply_below(supply_below), .bus_busy(bus_busy),
   .write_stop(write_stop), .rst_pin_oe(rst_pin_oe), .mem_enable(mem_enable), .bus_enable(bus_enable),
   .bus_abort(bus_abort), .prog_start(prog_start), .prog_busy(prog_busy));

// File: tb/srg_partner.sv
`timescale 1ns/1ps
module srg_partner (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // reset wire, pulled up
   input wire logic rst_pin_oe,
   input wire logic rst_pin_out,
   input wire logic force_low,
   output logic rst_pin_in,
   // bus master
   input wire logic mem_enable,
   input wire logic start_wr,
   input wire logic force_stop,
   output logic bus_busy,
   output logic write_stop
);
   logic [7:0] cnt;
   assign rst_pin_in = (rst_pin_oe ? rst_pin_out : 1'b1) & ~force_low;
   assign bus_busy = cnt != 8'h00;
   // a forced stop stands for a controller that ignores the reset line
   assign write_stop = (cnt == 8'h01) || force_stop;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst)
         cnt <= 8'h00;
      else if (!mem_enable)
         cnt <= 8'h00;
      else if (start_wr && cnt == 8'h00)
         cnt <= 8'h14;
      else if (cnt != 8'h00)
         cnt <= cnt - 8'h01;
   end
endmodule

// File: tb/srg_supervisor_tb.sv
`timescale 1ns/1ps
module srg_supervisor_tb;
   localparam int unsigned RTO = 200;
   localparam int unsigned PCC = 50;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic supply_below = 1'b1;
   logic force_low = 1'b0;
   logic start_wr = 1'b0;
   logic force_stop = 1'b0;
   logic rst_pin_in, rst_pin_out, rst_pin_oe, bus_busy, write_stop;
   logic mem_enable, bus_enable, bus_abort, prog_start, prog_busy;
   int n_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   int n;
   always #2.5 ref_clk = ~ref_clk;
   srg_supervisor #(.RESET_TIMEOUT_CYC(RTO), .PROGRAM_CYCLE_CYC(PCC)) srg_supervisor_inst (
      .ref_clk(ref_clk), .nrst(nrst), .supply_below(supply_below), .rst_pin_in(rst_pin_in),
      .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .bus_busy(bus_busy), .write_stop(write_stop),
      .mem_enable(mem_enable), .bus_enable(bus_enable), .bus_abort(bus_abort), .prog_start(prog_start),
      .prog_busy(prog_busy));
   srg_partner srg_partner_inst (.ref_clk(ref_clk), .nrst(nrst), .rst_pin_oe(rst_pin_oe),
      .rst_pin_out(rst_pin_out), .force_low(force_low), .rst_pin_in(rst_pin_in), .mem_enable(mem_enable),
      .start_wr(start_wr), .force_stop(force_stop), .bus_busy(bus_busy), .write_stop(write_stop));
   task print_verdict;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
      end
   endtask
   task tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task low_len(output int len);
      for (len = 0; len < 1000 && rst_pin_in === 1'b0; len++)
         tick(1);
   endtask
   task wait_run;
      for (int i = 0; i < 400 && mem_enable !== 1'b1; i++)
         tick(1);
   endtask
   // one pulse of k samples on the manual pin or the supply flag
   task pulse(input bit pin, input int k);
      @(posedge ref_clk);
      if (pin)
         force_low <= 1'b1;
      else
         supply_below <= 1'b1;
      repeat (k) @(posedge ref_clk);
      force_low <= 1'b0;
      supply_below <= 1'b0;
   endtask
   task t_powerup;
      low_len(n);
      check(n >= RTO, 1'b1);
      check(rst_pin_oe, 1'b0);
      check(rst_pin_in, 1'b1);
      wait_run;
      check(mem_enable, 1'b1);
   endtask
   task t_dip;
      pulse(1'b0, 6);
      tick(40);
      check(rst_pin_oe, 1'b0);
      check(mem_enable, 1'b1);
   endtask
   task t_manual;
      pulse(1'b1, 15);
      tick(40);
      check(rst_pin_oe, 1'b0);
      check(mem_enable, 1'b1);
      pulse(1'b1, 30);
      #1;
      check(rst_pin_oe, 1'b1);
      check(rst_pin_out, 1'b0);
      low_len(n);
      check(n + 30 >= RTO + 20, 1'b1);
      wait_run;
      check(bus_enable, 1'b1);
   endtask
   // supply trips mid-program while a second transfer is on the bus
   task t_trip;
      int ab;
      @(posedge ref_clk);
      start_wr <= 1'b1;
      @(posedge ref_clk);
      start_wr <= 1'b0;
      #1;
      for (n = 0; n < 100 && prog_start !== 1'b1; n++)
         tick(1);
      check(prog_start, 1'b1);
      check(bus_enable, 1'b0);
      @(posedge ref_clk);
      start_wr <= 1'b1;
      supply_below <= 1'b1;
      @(posedge ref_clk);
      start_wr <= 1'b0;
      #1;
      ab = 0;
      for (n = 2; n < 1000 && prog_busy === 1'b1; n++) begin
         ab |= bus_abort;
         tick(1);
      end
      check(n, PCC);
      check(ab, 1);
      check(rst_pin_oe, 1'b1);
      check(mem_enable, 1'b0);
      // a stop while in reset must not start programming
      @(posedge ref_clk);
      force_stop <= 1'b1;
      @(posedge ref_clk);
      force_stop <= 1'b0;
      tick(1);
      check(prog_busy, 1'b0);
      check(bus_enable, 1'b0);
      @(posedge ref_clk);
      supply_below <= 1'b0;
      wait_run;
      check(bus_enable, 1'b1);
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (20) @(posedge ref_clk);
      supply_below <= 1'b0;
      #1;
      t_powerup;
      t_dip;
      t_manual;
      t_trip;
      print_verdict;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         print_verdict;
      end
   end
endmodule
